// >>> verilog/imc_pkg.sv
package imc_pkg;

	// clock and clock-switch delay timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CSD_TIME_US   = 10;
	// least time, so round up to whole cycles
	localparam int CSD_CYCLES    =
		(CSD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CSD_CNT_W     = 8;
	localparam logic [CSD_CNT_W-1:0] CSD_LOAD =
		CSD_CNT_W'(CSD_CYCLES - 1);

	// synchroniser width: primary stable, secondary running
	localparam int SYNC_W        = 2;
	localparam int SYNC_PRI      = 0;
	localparam int SYNC_SEC      = 1;

	// register bus
	localparam int ADDR_W        = 4;
	localparam int DATA_W        = 8;
	localparam logic [ADDR_W-1:0] OSC_CTRL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] TMR_CTRL_ADDR = 4'h1;

	// oscillator_control fields
	localparam int IDLE_BIT      = 7;
	localparam int PRI_READY_BIT = 3;
	localparam int SEL_LSB       = 0;
	localparam int SEL_MSB       = 1;
	// secondary_timer_control fields
	localparam int SEC_ACT_BIT   = 6;
	localparam int SEC_EN_BIT    = 3;

	// clock select encodings
	localparam logic [1:0] SEL_PRIMARY   = 2'h0;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;

	// values after reset
	localparam logic       IDLE_RST     = 1'h0;
	localparam logic [1:0] SEL_RST      = 2'h0;
	localparam logic       SEC_EN_RST   = 1'h0;
	localparam logic [3:0] PRI_CFG_RST  = 4'h0;
	localparam logic [7:0] RDATA_RST    = 8'h00;

	// power-managed states
	typedef enum logic [2:0] {
		ST_PRIMARY_RUN_STATE    = 3'h0,
		ST_SECONDARY_RUN_STATE    = 3'h1,
		ST_PRIMARY_IDLE_STATE   = 3'h2,
		ST_SECONDARY_IDLE_STATE   = 3'h3,
		ST_SLEEP      = 3'h4,
		ST_WARM_PRI   = 3'h5,
		ST_SETTLE_PRI = 3'h6,
		ST_SETTLE_SEC = 3'h7
	} imc_state_t;

endpackage

// >>> verilog/imc_sync.sv
`timescale 1ns/1ps
module imc_sync
	import imc_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rstn_i,
	// asynchronous levels in, synchronised out
	input  wire logic [SYNC_W-1:0] async_i,
	output logic      [SYNC_W-1:0] sync_o
);

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} imc_sync_t;

	imc_sync_t q;
	imc_sync_t d;

	// first stage feeds only the second stage
	always_comb begin
		d    = q;
		d.s1 = async_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.s2;

endmodule

// >>> verilog/imc_dly.sv
`timescale 1ns/1ps
module imc_dly
	import imc_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	// start pulse, done pulse after the switch delay
	input  wire logic start_i,
	output logic      done_o
);

	typedef struct packed {
		logic                 busy;
		logic                 done;
		logic [CSD_CNT_W-1:0] cnt;
	} imc_dly_t;

	imc_dly_t q;
	imc_dly_t d;

	// a start while busy restarts the count
	always_comb begin
		d      = q;
		d.done = 1'b0;
		if (start_i) begin
			d.busy = 1'b1;
			d.cnt  = CSD_LOAD;
		end else if (q.busy) begin
			if (q.cnt == '0) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done_o = q.done;

endmodule

// >>> verilog/imc_top.sv
// Function
// RQ1 - primary idle keeps the primary clock running, only CPU clock gated
// RQ2 - software sets idle bit, clears select field, then sleeps
// RQ3 - primary idle stops CPU, peripherals clocked from configured primary
// RQ4 - primary ready flag stays set through primary idle and wake
// RQ5 - wake from primary idle holds CPU for the switch delay
// RQ6 - wake from primary idle leaves idle bit and select unchanged
// RQ7 - secondary idle stops CPU, peripherals run on secondary oscillator
// RQ8 - software sets idle bit, writes select 01, then sleeps
// RQ9 - switch to secondary stops primary, clears ready, sets active flag
// RQ10 - wake from secondary idle runs CPU on secondary after delay
// RQ11 - wake from secondary idle keeps bits, secondary oscillator runs
// RQ12 - sleep toward secondary idle ignored while secondary disabled
// RQ13 - peripheral clocks withheld until enabled secondary oscillator runs
// RQ14 - software starts secondary oscillator before requesting secondary idle
// RQ15 - secondary enable is timer control bit 3, 32 kHz crystal
// RQ16 - enabled secondary oscillator keeps running in every state
// RQ17 - software waits for secondary start-up, no hardware timer
// RQ18 - select field 01 switches CPU and peripherals to secondary
// RQ19 - secondary active flag, timer control bit 6, set while supplying
// RQ20 - any interrupt or reset wakes and starts the switch delay
`timescale 1ns/1ps
module imc_top
	import imc_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rstn_i,
	// register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	// core events
	input  wire logic              sleep_i,
	input  wire logic              wake_i,
	// oscillator status, asynchronous
	input  wire logic              pri_osc_stable_i,
	input  wire logic              sec_osc_running_i,
	// primary oscillator configuration field
	input  wire logic [3:0]        pri_osc_cfg_i,
	// clock controls
	output logic                   cpu_clk_en_o,
	output logic                   per_clk_en_o,
	output logic                   per_clk_sel_o,
	output logic                   pri_osc_en_o,
	output logic                   sec_osc_en_o,
	output logic      [3:0]        pri_osc_cfg_o
);

	typedef struct packed {
		imc_state_t           st;
		logic                 idle_bit;
		logic [1:0]           sel;
		logic                 sec_en;
		logic                 pri_ready;
		logic                 sec_active;
		logic                 cpu_en;
		logic                 per_en;
		logic                 per_sel;
		logic                 pri_en;
		logic [3:0]           cfg;
		logic [DATA_W-1:0]    rdata;
		logic [CSD_CNT_W-1:0] ast_cnt;
	} imc_top_t;

	imc_top_t q;
	imc_top_t d;

	logic [SYNC_W-1:0] osc_s;
	logic              pri_stable_s;
	logic              secondary_run_state_s;
	logic              dly_start;
	logic              dly_done;
	logic              sleep_idle;
	logic              sleep_deep;
	logic              want_sec;

	// oscillator status crosses in from the analogue side
	imc_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.async_i   ({sec_osc_running_i, pri_osc_stable_i}),
		.sync_o    (osc_s)
	);

	assign pri_stable_s = osc_s[SYNC_PRI];
	assign secondary_run_state_s    = osc_s[SYNC_SEC];

	// switch delay starts as a settle state is entered
	assign dly_start = (d.st != q.st) &&
		((d.st == ST_SETTLE_PRI) || (d.st == ST_SETTLE_SEC));

	imc_dly u_dly (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.start_i   (dly_start),
		.done_o    (dly_done)
	);

	// sleep request decoding from the stored configuration
	assign sleep_idle = sleep_i && q.idle_bit;
	assign sleep_deep = sleep_i && !q.idle_bit;
	assign want_sec   = (q.sel == SEL_SECONDARY);

	always_comb begin
		d       = q;
		d.rdata = RDATA_RST;

		// register writes; core is stopped while idle so none arrive then
		if (wr_i && addr_i == OSC_CTRL_ADDR) begin
			d.idle_bit = wdata_i[IDLE_BIT];
			d.sel      = wdata_i[SEL_MSB:SEL_LSB];
		end
		// RQ15 secondary enable bit
		if (wr_i && addr_i == TMR_CTRL_ADDR) begin
			d.sec_en = wdata_i[SEC_EN_BIT];
		end

		// read data stands only in the cycle after the strobe
		if (rd_i) begin
			unique case (addr_i)
				OSC_CTRL_ADDR: begin
					d.rdata[IDLE_BIT]        = q.idle_bit;
					d.rdata[PRI_READY_BIT]   = q.pri_ready;
					d.rdata[SEL_MSB:SEL_LSB] = q.sel;
				end
				// RQ19 active flag readable
				TMR_CTRL_ADDR: begin
					d.rdata[SEC_ACT_BIT] = q.sec_active;
					d.rdata[SEC_EN_BIT]  = q.sec_en;
				end
				default: begin
					d.rdata = RDATA_RST;
				end
			endcase
		end

		// power state sequencing; wake never touches idle bit or select
		unique case (q.st)
			ST_PRIMARY_RUN_STATE: begin
				if (sleep_deep) begin
					d.st = ST_SLEEP;
				// RQ12 sleep ignored when disabled
				end else if (sleep_idle && want_sec) begin
					if (q.sec_en) begin
						d.st = ST_SECONDARY_IDLE_STATE;
					end
				// RQ3 enter primary idle
				end else if (sleep_idle) begin
					d.st = ST_PRIMARY_IDLE_STATE;
				// RQ18 switch to secondary run
				end else if (want_sec && q.sec_en && secondary_run_state_s) begin
					d.st = ST_SETTLE_SEC;
				end
			end
			ST_SECONDARY_RUN_STATE: begin
				// primary request wins over a sleep in the same cycle
				if (!want_sec) begin
					d.st = ST_WARM_PRI;
				end else if (sleep_deep) begin
					d.st = ST_SLEEP;
				// RQ12 sleep ignored when disabled
				end else if (sleep_idle && q.sec_en) begin
					d.st = ST_SECONDARY_IDLE_STATE;
				end
			end
			// RQ5 wake holds CPU for the delay
			ST_PRIMARY_IDLE_STATE: begin
				if (wake_i) begin
					d.st = ST_SETTLE_PRI;
				end
			end
			// RQ10 RQ11 wake stays on secondary
			ST_SECONDARY_IDLE_STATE: begin
				if (wake_i) begin
					d.st = ST_SETTLE_SEC;
				end
			end
			// RQ20 interrupt wakes from sleep
			ST_SLEEP: begin
				if (wake_i && want_sec && q.sec_en) begin
					d.st = ST_SETTLE_SEC;
				end else if (wake_i) begin
					d.st = ST_WARM_PRI;
				end
			end
			ST_WARM_PRI: begin
				if (pri_stable_s) begin
					d.st = ST_SETTLE_PRI;
				end
			end
			ST_SETTLE_PRI: begin
				if (dly_done) begin
					d.st = ST_PRIMARY_RUN_STATE;
				end
			end
			ST_SETTLE_SEC: begin
				if (dly_done) begin
					d.st = ST_SECONDARY_RUN_STATE;
				end
			end
		endcase

		// RQ9 switch to secondary flags
		if (d.st == ST_SETTLE_SEC || d.st == ST_SECONDARY_IDLE_STATE) begin
			d.pri_ready  = 1'b0;
			d.sec_active = 1'b1;
		end else if (d.st == ST_SLEEP) begin
			d.pri_ready = 1'b0;
		end else if (d.st == ST_SETTLE_PRI) begin
			d.sec_active = 1'b0;
		end
		// RQ4 ready set once primary stable
		if (q.st == ST_WARM_PRI && pri_stable_s) begin
			d.pri_ready = 1'b1;
		end

		// clock enables follow the next state
		d.cpu_en  = (d.st == ST_PRIMARY_RUN_STATE) || (d.st == ST_SECONDARY_RUN_STATE);
		// RQ1 primary kept running in idle
		d.pri_en  = (d.st == ST_PRIMARY_RUN_STATE) || (d.st == ST_PRIMARY_IDLE_STATE) ||
			(d.st == ST_WARM_PRI) || (d.st == ST_SETTLE_PRI);
		d.per_sel = (d.st == ST_SECONDARY_RUN_STATE) || (d.st == ST_SECONDARY_IDLE_STATE) ||
			(d.st == ST_SETTLE_SEC) ||
			((d.st == ST_WARM_PRI) && d.sec_active);
		// RQ13 peripherals wait for secondary
		if (d.per_sel) begin
			d.per_en = secondary_run_state_s;
		end else begin
			d.per_en = d.pri_en && (d.st != ST_WARM_PRI);
		end
		// RQ3 configured primary source
		d.cfg = pri_osc_cfg_i;

		// cycles spent in a settle state, for checking only
		if (q.st == ST_SETTLE_PRI || q.st == ST_SETTLE_SEC) begin
			d.ast_cnt = q.ast_cnt + 1'b1;
		end else begin
			d.ast_cnt = '0;
		end
	end

	// RQ20 reset wakes via primary warm-up
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q            <= '0;
			q.st         <= ST_WARM_PRI;
			q.idle_bit   <= IDLE_RST;
			q.sel        <= SEL_RST;
			q.sec_en     <= SEC_EN_RST;
			q.pri_en     <= 1'b1;
			q.cfg        <= PRI_CFG_RST;
			q.rdata      <= RDATA_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign rdata_o       = q.rdata;
	assign cpu_clk_en_o  = q.cpu_en;
	assign per_clk_en_o  = q.per_en;
	assign per_clk_sel_o = q.per_sel;
	assign pri_osc_en_o  = q.pri_en;
	// RQ16 secondary follows its enable only
	assign sec_osc_en_o  = q.sec_en;
	assign pri_osc_cfg_o = q.cfg;

	AST_PRIMARY_IDLE_STATE_CLK: // RQ1
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_PRIMARY_IDLE_STATE) |-> pri_osc_en_o && !cpu_clk_en_o &&
		per_clk_en_o && !per_clk_sel_o)
		else $error("primary idle clocks wrong");

	AST_PRI_CFG: // RQ3
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_PRIMARY_IDLE_STATE) |=> (pri_osc_cfg_o == $past(pri_osc_cfg_i)))
		else $error("primary config not passed on");

	AST_PRI_READY_KEPT: // RQ4
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_PRIMARY_IDLE_STATE) && wake_i |-> q.pri_ready ##1 q.pri_ready
		##1 q.pri_ready)
		else $error("primary ready dropped across wake");

	AST_WAKE_PRI_HOLD: // RQ5
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_PRIMARY_IDLE_STATE) && wake_i |=> (q.st == ST_SETTLE_PRI) &&
		!cpu_clk_en_o && pri_osc_en_o)
		else $error("wake from primary idle not held");

	AST_SETTLE_LEN: // RQ20
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.ast_cnt != '0) && (q.st != ST_SETTLE_PRI) &&
		(q.st != ST_SETTLE_SEC) |-> (q.ast_cnt == CSD_LOAD + 8'h02))
		else $error("switch delay length wrong");

	AST_WAKE_KEEP: // RQ6
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		((q.st == ST_PRIMARY_IDLE_STATE) || (q.st == ST_SECONDARY_IDLE_STATE)) && wake_i &&
		!wr_i |=> $stable(q.idle_bit) && $stable(q.sel))
		else $error("wake changed idle bit or select");

	AST_SECONDARY_IDLE_STATE_CLK: // RQ7
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_SECONDARY_IDLE_STATE) |-> !cpu_clk_en_o && per_clk_sel_o &&
		!pri_osc_en_o)
		else $error("secondary idle clocks wrong");

	AST_SEC_SWITCH: // RQ9
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_SETTLE_SEC) |-> !q.pri_ready && q.sec_active &&
		!pri_osc_en_o)
		else $error("switch to secondary flags wrong");

	AST_SLEEP_IGNORED: // RQ12
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		((q.st == ST_PRIMARY_RUN_STATE) || (q.st == ST_SECONDARY_RUN_STATE)) && want_sec &&
		sleep_idle && !q.sec_en |=> $stable(q.st))
		else $error("sleep not ignored with secondary off");

	AST_SEC_WITHHOLD: // RQ13
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(d.st == ST_SECONDARY_IDLE_STATE) && !secondary_run_state_s |=> !per_clk_en_o)
		else $error("peripheral clock before secondary runs");

	AST_SEC_FLAG_READ: // RQ19
	assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(q.st == ST_SECONDARY_RUN_STATE) && rd_i && (addr_i == TMR_CTRL_ADDR)
		|=> rdata_o[SEC_ACT_BIT])
		else $error("secondary active flag not read as set");

endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import imc_pkg::*;
;
	// clock and reset
	logic              clk_sys_i;
	logic              rstn_i;
	// register port
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i;
	logic              wr_i;
	logic              rd_i;
	logic [DATA_W-1:0] rdata_o;
	// core events and oscillator status
	logic              sleep_i;
	logic              wake_i;
	logic              pri_osc_stable_i;
	logic              sec_osc_running_i;
	logic [3:0]        pri_osc_cfg_i;
	// clock controls
	logic              cpu_clk_en_o;
	logic              per_clk_en_o;
	logic              per_clk_sel_o;
	logic              pri_osc_en_o;
	logic              sec_osc_en_o;
	logic [3:0]        pri_osc_cfg_o;
	// bookkeeping
	int                fail_count;
	int                check_count;
	int                n;

	imc_top i_dut (
		.clk_sys_i         (clk_sys_i),
		.rstn_i            (rstn_i),
		.addr_i            (addr_i),
		.wdata_i           (wdata_i),
		.wr_i              (wr_i),
		.rd_i              (rd_i),
		.rdata_o           (rdata_o),
		.sleep_i           (sleep_i),
		.wake_i            (wake_i),
		.pri_osc_stable_i  (pri_osc_stable_i),
		.sec_osc_running_i (sec_osc_running_i),
		.pri_osc_cfg_i     (pri_osc_cfg_i),
		.cpu_clk_en_o      (cpu_clk_en_o),
		.per_clk_en_o      (per_clk_en_o),
		.per_clk_sel_o     (per_clk_sel_o),
		.pri_osc_en_o      (pri_osc_en_o),
		.sec_osc_en_o      (sec_osc_en_o),
		.pri_osc_cfg_o     (pri_osc_cfg_o)
	);

	// 10 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// compare as four-state so an unknown never matches
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e,
		input string what);
		@(posedge clk_sys_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i   <= 1'b0;
		@(negedge clk_sys_i);
		chk(rdata_o, e, what);
	endtask

	// one-cycle sleep or wake pulse
	task automatic evt(input logic s);
		@(posedge clk_sys_i);
		if (s) begin
			sleep_i <= 1'b1;
		end else begin
			wake_i <= 1'b1;
		end
		@(posedge clk_sys_i);
		sleep_i <= 1'b0;
		wake_i  <= 1'b0;
	endtask

	// cycles with the cpu held, bounded so a hang ends the run
	task automatic cpu_off_count(output int cnt);
		cnt = 0;
		for (int i = 0; i < 1000; i++) begin
			@(negedge clk_sys_i);
			if (cpu_clk_en_o === 1'b1) begin
				break;
			end
			cnt++;
		end
		if (cnt >= 1000) begin
			fail_count++;
			$display("ERROR t=%0t cpu clock never resumed", $time);
			finish_test();
		end
	endtask

	// register values after reset, read-only bit, unmapped address
	task automatic t_regs();
		cpu_off_count(n);
		rd(OSC_CTRL_ADDR, 8'h08, "osc ctrl reset"); // ready set
		rd(TMR_CTRL_ADDR, 8'h00, "tmr ctrl reset"); // enable off
		wr(OSC_CTRL_ADDR, 8'h00);
		rd(OSC_CTRL_ADDR, 8'h08, "ready read-only"); // flag kept
		wr(4'h5, 8'hFF);
		rd(4'h5, 8'h00, "unmapped read");
	endtask

	// primary idle entry and wake
	task automatic t_primary_idle_state();
		wr(OSC_CTRL_ADDR, 8'h80);
		evt(1'b1);
		repeat (2) @(negedge clk_sys_i);
		chk({7'h00, cpu_clk_en_o}, 8'h00, "cpu in primary_idle_state");
		chk({7'h00, per_clk_en_o}, 8'h01, "per in primary_idle_state");
		chk({7'h00, per_clk_sel_o}, 8'h00, "per sel pri");
		chk({7'h00, pri_osc_en_o}, 8'h01, "pri osc on");
		chk({4'h0, pri_osc_cfg_o}, 8'h0A, "pri cfg");
		rd(OSC_CTRL_ADDR, 8'h88, "ready in idle");
		evt(1'b0);
		cpu_off_count(n);
		chk(8'(n), 8'(CSD_CYCLES + 1), "pri wake delay");
		rd(OSC_CTRL_ADDR, 8'h88, "bits after wake");
		wr(OSC_CTRL_ADDR, 8'h00);
	endtask

	// secondary idle refused while the oscillator is disabled
	task automatic t_sec_refused();
		wr(OSC_CTRL_ADDR, 8'h80);
		wr(OSC_CTRL_ADDR, 8'h81);
		evt(1'b1);
		repeat (3) @(negedge clk_sys_i);
		chk({7'h00, cpu_clk_en_o}, 8'h01, "sleep ignored");
		chk({7'h00, per_clk_sel_o}, 8'h00, "still primary");
		wr(OSC_CTRL_ADDR, 8'h00);
	endtask

	// secondary run, secondary idle, stalled oscillator, wake
	task automatic t_secondary_idle_state();
		wr(TMR_CTRL_ADDR, 8'h08);
		repeat (2) @(negedge clk_sys_i);
		chk({7'h00, sec_osc_en_o}, 8'h01, "sec enable out");
		wr(OSC_CTRL_ADDR, 8'h80);
		wr(OSC_CTRL_ADDR, 8'h81);
		// switch lands one edge after the write, cpu still on here
		@(negedge clk_sys_i);
		cpu_off_count(n);
		chk(8'(n), 8'(CSD_CYCLES + 1), "sec switch delay");
		chk({7'h00, per_clk_sel_o}, 8'h01, "per on sec");
		chk({7'h00, pri_osc_en_o}, 8'h00, "pri osc off");
		rd(TMR_CTRL_ADDR, 8'h48, "active flag");
		rd(OSC_CTRL_ADDR, 8'h81, "ready cleared");
		evt(1'b1);
		repeat (2) @(negedge clk_sys_i);
		chk({7'h00, cpu_clk_en_o}, 8'h00, "cpu in secondary_idle_state");
		chk({7'h00, per_clk_en_o}, 8'h01, "per in secondary_idle_state");
		chk({7'h00, per_clk_sel_o}, 8'h01, "sel in secondary_idle_state");
		chk({7'h00, sec_osc_en_o}, 8'h01, "sec osc in idle");
		// stalled oscillator must hold peripheral clocks off
		@(posedge clk_sys_i);
		sec_osc_running_i <= 1'b0;
		repeat (4) @(negedge clk_sys_i);
		chk({7'h00, per_clk_en_o}, 8'h00, "per held");
		@(posedge clk_sys_i);
		sec_osc_running_i <= 1'b1;
		repeat (4) @(negedge clk_sys_i);
		chk({7'h00, per_clk_en_o}, 8'h01, "per resumed");
		evt(1'b0);
		@(negedge clk_sys_i);
		chk({7'h00, per_clk_sel_o}, 8'h01, "sel in settle");
		cpu_off_count(n);
		chk(8'(n + 1), 8'(CSD_CYCLES + 1), "sec wake delay");
		chk({7'h00, per_clk_sel_o}, 8'h01, "sel after wake");
		chk({7'h00, sec_osc_en_o}, 8'h01, "sec osc kept");
		rd(OSC_CTRL_ADDR, 8'h81, "bits after sec wake");
		rd(TMR_CTRL_ADDR, 8'h48, "flag after sec wake");
	endtask

	// secondary run back to primary, then primary idle and wake
	task automatic t_back_pri();
		wr(OSC_CTRL_ADDR, 8'h81);
		wr(OSC_CTRL_ADDR, 8'h80);
		// warm-up starts one edge after the write
		@(negedge clk_sys_i);
		cpu_off_count(n);
		chk({7'h00, per_clk_sel_o}, 8'h00, "back on primary");
		evt(1'b1);
		repeat (2) @(negedge clk_sys_i);
		chk({7'h00, cpu_clk_en_o}, 8'h00, "cpu in primary_idle_state 2");
		chk({7'h00, pri_osc_en_o}, 8'h01, "pri osc on 2");
		rd(OSC_CTRL_ADDR, 8'h88, "ready in idle 2");
		evt(1'b0);
		cpu_off_count(n);
		chk(8'(n), 8'(CSD_CYCLES + 1), "pri wake delay 2");
	endtask

	// main sequence, reset held for ten cycles
	initial begin
		fail_count        = 0;
		check_count       = 0;
		rstn_i            = 1'b0;
		addr_i            = 4'h0;
		wdata_i           = 8'h00;
		wr_i              = 1'b0;
		rd_i              = 1'b0;
		sleep_i           = 1'b0;
		wake_i            = 1'b0;
		pri_osc_stable_i  = 1'b1;
		sec_osc_running_i = 1'b1;
		pri_osc_cfg_i     = 4'hA;
		repeat (10) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_regs();
		t_primary_idle_state();
		t_sec_refused();
		t_secondary_idle_state();
		t_back_pri();
		finish_test();
	end

endmodule
